// *** bench/ldpr_user.sv ***
// Behavioural user logic driving one port of the large RAM
module ldpr_user (
    // Clock
    input  wire logic                        clk_sys,
    // Port controls
    output logic                             en,
    output logic                             clr,
    output logic                             we,
    output logic [ldpr_pkg::PORT_AW-1:0]     addr,
    output logic [ldpr_pkg::MASK_W-1:0]      mask,
    output logic [ldpr_pkg::PIN_W-1:0]       wdata,
    // Read data
    input  wire logic [ldpr_pkg::PIN_W-1:0]  rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import ldpr_pkg::*;

    initial begin
        en    = 1'b0;
        clr   = 1'b0;
        we    = 1'b0;
        addr  = '0;
        mask  = '1;
        wdata = '0;
    end

    // Released lines flip so stale values never pass for a match
    task automatic release_port();
        en    = 1'b0;
        we    = ~we;
        addr  = ~addr;
        mask  = ~mask;
        wdata = ~wdata;
    endtask

    // One write selected by the single write-enable line
    task automatic wr(input logic [15:0] a, input logic [7:0] m,
                      input logic [71:0] d, input bit e);
        @(posedge clk_sys);
        #1;
        en    = e;
        we    = 1'b1;
        addr  = a;
        mask  = m;
        wdata = d;
        @(posedge clk_sys);
        #1;
        release_port();
    endtask

    // Read held for hold edges; data sampled after E+2 and E+3
    task automatic rd(input logic [15:0] a, input int hold,
                      output logic [71:0] v2, output logic [71:0] v3);
        @(posedge clk_sys);
        #1;
        en   = 1'b1;
        we   = 1'b0;
        addr = a;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            #1;
            if (k == hold - 1) begin
                release_port();
            end
            if (k == 2) begin
                v2 = rdata;
            end
            if (k == 3) begin
                v3 = rdata;
            end
        end
    endtask

    // Port clear for one edge
    task automatic pulse_clear();
        @(posedge clk_sys);
        #1;
        clr = 1'b1;
        @(posedge clk_sys);
        #1;
        clr = 1'b0;
    endtask
endmodule

// *** bench/test_large_dual_port_ram.sv ***
// Self-checking bench for the large dual-port RAM, random and corner cases
`define CHECK_EQ(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module test_large_dual_port_ram;
    timeunit 1ns;
    timeprecision 100ps;
    import ldpr_pkg::*;

    logic                clk_sys;
    logic                srst;
    logic                en_a, clr_a, we_a, en_b, clr_b, we_b;
    logic [PORT_AW-1:0]  addr_a, addr_b;
    logic [MASK_W-1:0]   mask_a, mask_b;
    logic [PIN_W-1:0]    wdata_a, rdata_a, wdata_b, rdata_b;
    int                  n_errors;
    int                  checks_done;
    int                  cycles;
    logic [31:0]         seed;
    logic [71:0]         shadow [16];
    logic [71:0]         v2, v3, d;
    logic [31:0]         r;
    // Second instance: wide simple dual-port, A bypassed, B registered
    logic                en_wa, clr_wa, we_wa, en_wb, clr_wb, we_wb;
    logic [PORT_AW-1:0]  addr_wa, addr_wb;
    logic [MASK_W-1:0]   mask_wa, mask_wb;
    logic [PIN_W-1:0]    wdata_wa, rdata_wa, wdata_wb, rdata_wb;
    logic [143:0]        wshadow [4];

    // Port B bypasses its output register so both latencies are seen
    ldpr_ram #(
        .MODE      (LDPR_TDP),
        .WIDTH_A   (72),
        .WIDTH_B   (72),
        .OUT_REG_A (1'b1),
        .OUT_REG_B (1'b0)
    ) dut_u (
        .clk_sys (clk_sys), .srst    (srst),
        .en_a    (en_a),    .clr_a   (clr_a),   .we_a    (we_a),
        .addr_a  (addr_a),  .mask_a  (mask_a),
        .wdata_a (wdata_a), .rdata_a (rdata_a),
        .en_b    (en_b),    .clr_b   (clr_b),   .we_b    (we_b),
        .addr_b  (addr_b),  .mask_b  (mask_b),
        .wdata_b (wdata_b), .rdata_b (rdata_b)
    );

    ldpr_user user_a (
        .clk_sys (clk_sys), .en (en_a), .clr (clr_a), .we (we_a),
        .addr (addr_a), .mask (mask_a), .wdata (wdata_a), .rdata (rdata_a)
    );
    ldpr_user user_b (
        .clk_sys (clk_sys), .en (en_b), .clr (clr_b), .we (we_b),
        .addr (addr_b), .mask (mask_b), .wdata (wdata_b), .rdata (rdata_b)
    );

    ldpr_ram #(
        .MODE      (LDPR_SDP),
        .WIDTH_A   (144),
        .WIDTH_B   (144),
        .OUT_REG_A (1'b0),
        .OUT_REG_B (1'b1)
    ) dut_wide (
        .clk_sys (clk_sys),  .srst    (srst),
        .en_a    (en_wa),    .clr_a   (clr_wa),   .we_a    (we_wa),
        .addr_a  (addr_wa),  .mask_a  (mask_wa),
        .wdata_a (wdata_wa), .rdata_a (rdata_wa),
        .en_b    (en_wb),    .clr_b   (clr_wb),   .we_b    (we_wb),
        .addr_b  (addr_wb),  .mask_b  (mask_wb),
        .wdata_b (wdata_wb), .rdata_b (rdata_wb)
    );

    ldpr_user user_wa (
        .clk_sys (clk_sys), .en (en_wa), .clr (clr_wa), .we (we_wa),
        .addr (addr_wa), .mask (mask_wa), .wdata (wdata_wa),
        .rdata (rdata_wa)
    );
    ldpr_user user_wb (
        .clk_sys (clk_sys), .en (en_wb), .clr (clr_wb), .we (we_wb),
        .addr (addr_wb), .mask (mask_wb), .wdata (wdata_wb),
        .rdata (rdata_wb)
    );

    always #5 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [71:0] rnd72();
        logic [95:0] t;
        t = {xs(), xs(), xs()};
        return t[71:0];
    endfunction

    // Top rows of the 8K space, upper ignored bits randomised
    function automatic logic [15:0] ad(input logic [3:0] i);
        logic [31:0] t;
        t = xs();
        return {t[2:0], 9'h1FF, i};
    endfunction

    // Lane i of a 72-bit word is bits 9i+8 down to 9i
    function automatic logic [71:0] merge(input logic [71:0] o,
        input logic [71:0] nd, input logic [7:0] m);
        logic [71:0] res;
        res = o;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                res[9*i +: 9] = nd[9*i +: 9];
            end
        end
        return res;
    endfunction

    task automatic op(input bit p, input bit w, input logic [3:0] i,
                      input logic [7:0] m, input logic [71:0] dd,
                      input bit e);
        if (w) begin
            if (p) begin
                user_b.wr(ad(i), m, dd, e);
            end else begin
                user_a.wr(ad(i), m, dd, e);
            end
            if (e) begin
                shadow[i] = merge(shadow[i], dd, m);
            end
        end else if (p) begin
            user_b.rd(ad(i), 4, v2, v3);
            `CHECK_EQ(v2, shadow[i])
        end else begin
            user_a.rd(ad(i), 4, v2, v3);
            `CHECK_EQ(v3, shadow[i])
        end
    endtask

    // Wide row: A carries lanes 0-7, B lanes 8-15 and the high mask
    task automatic wop(input bit w, input logic [1:0] i,
                       input logic [15:0] m, input logic [143:0] dd);
        logic [15:0] a;
        logic [71:0] lo, hi, x1, x2;
        a = ad({2'b00, i});
        if (w) begin
            fork
                user_wa.wr(a, m[7:0], dd[71:0], 1'b1);
                user_wb.wr(a, m[15:8], dd[143:72], 1'b1);
            join
            wshadow[i] = {merge(wshadow[i][143:72], dd[143:72], m[15:8]),
                          merge(wshadow[i][71:0], dd[71:0], m[7:0])};
        end else begin
            fork
                user_wa.rd(a, 4, lo, x1);
                user_wb.rd(a, 4, x2, hi);
            join
            `CHECK_EQ({hi, lo}, wshadow[i])
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, errors %0d", name, n_errors);
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs about 1500 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        seed = 32'h0000_0ED5;
        repeat (12) @(posedge clk_sys);
        #1;
        `CHECK_EQ(rdata_a, 72'h0)
        `CHECK_EQ(rdata_b, 72'h0)
        `CHECK_EQ({rdata_wb, rdata_wa}, 144'h0)
        srst = 1'b0;
        end_test("reset");
        // Every row written whole before any read: no preload exists
        for (int i = 0; i < 16; i++) begin
            op(i[0], 1'b1, i[3:0], 8'hFF, rnd72(), 1'b1);
        end
        for (int i = 0; i < 16; i++) begin
            op(1'b0, 1'b0, i[3:0], 8'h00, '0, 1'b1);
            op(1'b1, 1'b0, i[3:0], 8'h00, '0, 1'b1);
        end
        end_test("fill");
        // Single lanes, then nothing, then everything
        for (int k = 0; k < 10; k++) begin
            r = (k < 8) ? (32'h1 << k) : ((k == 8) ? 32'h0 : 32'hFF);
            op(1'b1, 1'b1, 4'h5, r[7:0], rnd72(), 1'b1);
            op(1'b0, 1'b0, 4'h5, 8'h00, '0, 1'b1);
            op(1'b1, 1'b0, 4'h5, 8'h00, '0, 1'b1);
        end
        end_test("lanes");
        // Disabled write leaves the row alone
        op(1'b0, 1'b1, 4'h3, 8'hFF, rnd72(), 1'b0);
        op(1'b1, 1'b0, 4'h3, 8'h00, '0, 1'b1);
        // Output register holds while its enable is low at E+3
        user_a.rd(ad(4'h3), 4, v2, v3);
        user_a.rd(ad(4'h7), 3, v2, v3);
        `CHECK_EQ(v3, shadow[3])
        user_a.rd(ad(4'h7), 4, v2, v3);
        `CHECK_EQ(v3, shadow[7])
        // Clear of port A leaves port B untouched
        user_b.rd(ad(4'h9), 4, v2, v3);
        user_a.pulse_clear();
        `CHECK_EQ(rdata_a, 72'h0)
        `CHECK_EQ(rdata_b, shadow[9])
        end_test("enable_clear");
        for (int n = 0; n < 300; n++) begin
            r = xs();
            d = rnd72();
            op(r[0], r[1], r[5:2], r[13:6], d, 1'b1);
        end
        end_test("random");
        // Four wide rows filled whole, then masked writes and reads
        for (int n = 0; n < 28; n++) begin
            r = xs();
            wop(n < 4 || r[0], (n < 4) ? n[1:0] : r[2:1],
                (n < 4) ? 16'hFFFF : r[18:3], {rnd72(), rnd72()});
        end
        wop(1'b1, 2'd1, 16'h8001, {rnd72(), rnd72()});
        wop(1'b0, 2'd1, 16'h0000, '0);
        wop(1'b1, 2'd2, 16'h0000, {rnd72(), rnd72()});
        wop(1'b0, 2'd2, 16'h0000, '0);
        end_test("wide");
        results();
    end
endmodule

// *** rtl/ldpr_array.sv ***
// Storage array of 4096 rows by sixteen 9-bit lanes, two access ports
module ldpr_array (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Access ports
    ldpr_port_if.mem  port_a,
    ldpr_port_if.mem  port_b
);
    import ldpr_pkg::*;

    typedef struct packed {
        logic [1:0][WORD_W-1:0] rd;
    } ldpr_arr_state_t;

    ldpr_arr_state_t   st_q;
    ldpr_arr_state_t   st_d;
    // No initial contents: rows stay unknown until written
    logic [WORD_W-1:0] mem_q [DEPTH];

    if (DEPTH * WORD_W != ARRAY_BITS) begin : g_bad_size
        $error("ldpr_array: storage size mismatch");
    end

    always_comb begin
        st_d = st_q;
        if (port_a.rd) begin
            st_d.rd[0] = mem_q[port_a.addr];
        end
        if (port_b.rd) begin
            st_d.rd[1] = mem_q[port_b.addr];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Lanes left unwritten keep their old value; port B wins a collision
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LANES; i++) begin
            if (port_a.lane_we[i]) begin
                mem_q[port_a.addr][LANE_W*i +: LANE_W] <=
                    port_a.wdata[LANE_W*i +: LANE_W];
            end
            if (port_b.lane_we[i]) begin
                mem_q[port_b.addr][LANE_W*i +: LANE_W] <=
                    port_b.wdata[LANE_W*i +: LANE_W];
            end
        end
    end

    assign port_a.rdata = st_q.rd[0];
    assign port_b.rdata = st_q.rd[1];
endmodule

// *** rtl/ldpr_ram.sv ***
// Large dual-port RAM: port capture, lane steering and read pipeline

// Functional notes
// - Array holds 589,824 bits including the ninth bit of each lane.
// - Modes: true dual-port, simple dual-port, single-port, FIFO.
// - No preload; contents are undefined until written.
// - Every input is registered; no asynchronous read or write path.
// - Each read output register may be bypassed at configuration.
// - Shapes 64Kx8/9 up to 4Kx128/144 per port.
// - 128/144-bit shape refused in true dual-port mode.
// - Simple dual-port: 9..72 widths mix freely; 144 pairs only itself.
// - True dual-port: each port takes any width 9 to 72.
// - One write enable per port: high writes, low reads.
// - Only lanes with mask high are written; unused mask defaults high.
// - Masks in 18, 36, 72 widths use 2, 4, 8 bits.
// - 144-bit width joins both masks into one 16-bit mask.
// - Mask bit i gates data bits 9i+8 down to 9i.
// - Without parity each mask bit gates one 8-bit byte.
// - Any mask pattern is accepted, all low writes nothing.
// - All input registers of a port share one clock.
// - Each port has own clock enable, write select and clear.
// - Each port has 72 data inputs and 72 data outputs.
// - Masked lanes keep their last written value.
// - Each port's clear and enable act on that port's registers.
module ldpr_ram #(
    parameter ldpr_pkg::ldpr_mode_t MODE      = ldpr_pkg::LDPR_TDP,
    parameter int                   WIDTH_A   = ldpr_pkg::DEF_WIDTH,
    parameter int                   WIDTH_B   = ldpr_pkg::DEF_WIDTH,
    parameter bit                   OUT_REG_A = 1'b1,
    parameter bit                   OUT_REG_B = 1'b1
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    // Port A controls
    input  wire logic                          en_a,
    input  wire logic                          clr_a,
    input  wire logic                          we_a,
    input  wire logic [ldpr_pkg::PORT_AW-1:0]  addr_a,
    input  wire logic [ldpr_pkg::MASK_W-1:0]   mask_a,
    // Port A data
    input  wire logic [ldpr_pkg::PIN_W-1:0]    wdata_a,
    output logic      [ldpr_pkg::PIN_W-1:0]    rdata_a,
    // Port B controls
    input  wire logic                          en_b,
    input  wire logic                          clr_b,
    input  wire logic                          we_b,
    input  wire logic [ldpr_pkg::PORT_AW-1:0]  addr_b,
    input  wire logic [ldpr_pkg::MASK_W-1:0]   mask_b,
    // Port B data
    input  wire logic [ldpr_pkg::PIN_W-1:0]    wdata_b,
    output logic      [ldpr_pkg::PIN_W-1:0]    rdata_b
);
    import ldpr_pkg::*;

    localparam int         LN_A   = ldpr_lanes(WIDTH_A);
    localparam int         LN_B   = ldpr_lanes(WIDTH_B);
    localparam bit         WIDE   = (LN_A == LANES);
    localparam int         LN [2] = '{LN_A, LN_B};
    localparam int         SPAN [2] = '{LANES / LN_A, LANES / LN_B};
    localparam int         SH [2] = '{$clog2(LANES / LN_A),
                                      $clog2(LANES / LN_B)};
    localparam bit         PAR [2] = '{ldpr_parity(WIDTH_A),
                                       ldpr_parity(WIDTH_B)};
    localparam bit         OREG [2] = '{OUT_REG_A, OUT_REG_B};
    localparam logic [1:0] WR_OK  = (MODE == LDPR_TDP) ? 2'h3 : 2'h1;
    localparam logic [1:0] RD_OK  = (MODE == LDPR_TDP) ? 2'h3 :
                                    (MODE == LDPR_SP)  ? 2'h1 : 2'h2;

    // Shapes the array cannot serve are refused at elaboration
    if (!ldpr_width_ok(WIDTH_A) || !ldpr_width_ok(WIDTH_B)) begin : g_w
        $error("ldpr_ram: unsupported port width");
    end
    if (ldpr_parity(WIDTH_A) != ldpr_parity(WIDTH_B)) begin : g_par
        $error("ldpr_ram: ports differ in parity lanes");
    end
    // Only 144 output drivers, so a wide port leaves none for a true dual-port partner
    if (MODE == LDPR_TDP && (LN_A == LANES || LN_B == LANES)) begin : g_t
        $error("ldpr_ram: wide shape refused in true dual-port");
    end
    if (MODE == LDPR_SP && LN_A == LANES) begin : g_s
        $error("ldpr_ram: wide shape needs simple dual-port");
    end
    if ((MODE == LDPR_SDP || MODE == LDPR_FIFO)
        && ((LN_A == LANES) != (LN_B == LANES))) begin : g_d
        $error("ldpr_ram: wide width pairs only with itself");
    end

    typedef struct packed {
        logic [1:0]              act;
        logic [1:0]              we;
        logic [1:0][PORT_AW-1:0] addr;
        logic [1:0][MASK_W-1:0]  mask;
        logic [1:0][PIN_W-1:0]   wd;
        logic [1:0]              rdv;
        logic [1:0][LANE_IW-1:0] off2;
        logic [1:0][PIN_W-1:0]   stg;
        logic [1:0][PIN_W-1:0]   out;
    } ldpr_state_t;

    ldpr_state_t             st_q;
    ldpr_state_t             st_d;
    logic [1:0]              in_en;
    logic [1:0]              in_clr;
    logic [1:0]              in_we;
    logic [1:0][PORT_AW-1:0] in_addr;
    logic [1:0][MASK_W-1:0]  in_mask;
    logic [1:0][PIN_W-1:0]   in_wd;
    logic [1:0]              c_rd;
    logic [1:0][LANES-1:0]   c_lwe;
    logic [1:0][WORD_AW-1:0] c_addr;
    logic [1:0][WORD_W-1:0]  c_wd;
    logic [1:0][WORD_W-1:0]  a_rd;
    logic [1:0][WORD_W-1:0]  r_al;
    logic [LANES-1:0]        h_mask_a;

    // Both ports run on the one system clock
    assign in_en   = {en_b, en_a};
    assign in_clr  = {clr_b, clr_a};
    assign in_we   = {we_b, we_a};
    assign in_addr = {addr_b, addr_a};
    assign in_mask = {mask_b, mask_a};
    assign in_wd   = {wdata_b, wdata_a};

    always_comb begin
        int                 k;
        int                 ln;
        logic [LANE_IW-1:0] off;
        logic [WORD_W-1:0]  wsrc;
        logic [LANES-1:0]   msrc;
        logic [PIN_W-1:0]   src;
        logic               vld;
        k      = 0;
        ln     = 1;
        off    = '0;
        wsrc   = '0;
        msrc   = '0;
        src    = '0;
        vld    = 1'b0;
        st_d   = st_q;
        c_rd   = '0;
        c_lwe  = '0;
        c_addr = '0;
        c_wd   = '0;
        r_al   = '0;
        for (int p = 0; p < 2; p++) begin
            ln = LN[p];
            // One clock captures select, data, address and mask together
            st_d.act[p] = in_en[p] & ~in_clr[p];
            if (in_clr[p]) begin
                st_d.we[p]   = 1'b0;
                st_d.addr[p] = '0;
                st_d.mask[p] = '0;
                st_d.wd[p]   = '0;
            end else if (in_en[p]) begin
                st_d.we[p]   = in_we[p];
                st_d.addr[p] = in_addr[p];
                st_d.mask[p] = in_mask[p];
                st_d.wd[p]   = in_wd[p];
            end

            // Narrow words pack into a row; low address bits pick lanes
            off = LANE_IW'((int'(st_q.addr[p]) % SPAN[p]) * ln);
            c_addr[p] = WORD_AW'(st_q.addr[p] >> SH[p]);

            // The wide shape writes through both pin sets at once
            wsrc = WIDE ? {st_q.wd[1], st_q.wd[0]}
                        : {{PIN_W{1'b0}}, st_q.wd[p]};
            msrc = WIDE ? {st_q.mask[1], st_q.mask[0]}
                        : {{MASK_W{1'b0}}, st_q.mask[p]};

            for (int i = 0; i < LANES; i++) begin
                k = i - int'(off);
                if (k >= 0 && k < ln) begin
                    // Single-lane shapes have no mask: enable alone rules
                    c_lwe[p][i] = WR_OK[p] & st_q.act[p] & st_q.we[p]
                                  & (ln == 1 || msrc[k]);
                    if (PAR[p]) begin
                        c_wd[p][LANE_W*i +: LANE_W] =
                            wsrc[LANE_W*k +: LANE_W];
                    end else begin
                        c_wd[p][LANE_W*i +: LANE_W] =
                            {1'b0, wsrc[BYTE_W*k +: BYTE_W]};
                    end
                end
            end

            // Low select reads; the port role follows the mode
            c_rd[p] = RD_OK[p] & st_q.act[p] & ~st_q.we[p];
            st_d.rdv[p] = c_rd[p] & ~in_clr[p];
            if (c_rd[p]) begin
                st_d.off2[p] = off;
            end

            for (int j = 0; j < LANES; j++) begin
                k = j + int'(st_q.off2[p]);
                if (j < ln) begin
                    if (PAR[p]) begin
                        r_al[p][LANE_W*j +: LANE_W] =
                            a_rd[p][LANE_W*k +: LANE_W];
                    end else begin
                        r_al[p][BYTE_W*j +: BYTE_W] =
                            a_rd[p][LANE_W*k +: BYTE_W];
                    end
                end
            end
        end

        for (int p = 0; p < 2; p++) begin
            // Wide reads come in on B and leave on both pin sets
            src = WIDE ? r_al[1][PIN_W*p +: PIN_W]
                       : r_al[p][PIN_W-1:0];
            vld = WIDE ? st_q.rdv[1] : st_q.rdv[p];
            if (OREG[p]) begin
                if (vld) begin
                    st_d.stg[p] = src;
                end
                if (in_en[p]) begin
                    st_d.out[p] = st_q.stg[p];
                end
            end else if (vld) begin
                st_d.out[p] = src;
            end
            if (in_clr[p]) begin
                st_d.stg[p] = '0;
                st_d.out[p] = '0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ldpr_port_if pif_a ();
    ldpr_port_if pif_b ();

    assign pif_a.rd      = c_rd[0];
    assign pif_a.lane_we = c_lwe[0];
    assign pif_a.addr    = c_addr[0];
    assign pif_a.wdata   = c_wd[0];
    assign pif_b.rd      = c_rd[1];
    assign pif_b.lane_we = c_lwe[1];
    assign pif_b.addr    = c_addr[1];
    assign pif_b.wdata   = c_wd[1];
    assign a_rd[0]       = pif_a.rdata;
    assign a_rd[1]       = pif_b.rdata;

    ldpr_array u_array (
        .clk_sys (clk_sys),
        .srst    (srst),
        .port_a  (pif_a),
        .port_b  (pif_b)
    );

    assign rdata_a = st_q.out[0];
    assign rdata_b = st_q.out[1];

    // Lanes port A is allowed to touch this cycle, for the checks below
    assign h_mask_a = WIDE ? {st_q.mask[1], st_q.mask[0]}
                           : ({{MASK_W{1'b0}}, st_q.mask[0]}
                              & LANES'((1 << LN_A) - 1));

    a_input_regd: assert property (
        @(posedge clk_sys) disable iff (srst)
        (en_a && !clr_a) |=> (st_q.act[0] && st_q.we[0] == $past(we_a)))
        else $error("port A inputs not captured on enable");

    a_write_sel: assert property (
        @(posedge clk_sys) disable iff (srst)
        (|c_lwe[0]) |-> ($past(we_a) && $past(en_a) && !c_rd[0]))
        else $error("port A wrote without a captured write select");

    a_mask_count: assert property (
        @(posedge clk_sys) disable iff (srst)
        (st_q.act[0] && st_q.we[0]) |->
        ($countones(c_lwe[0]) ==
         ((LN_A == 1) ? 1 : $countones(h_mask_a))))
        else $error("port A lane enables do not follow the mask");

    a_wide_mask: assert property (
        @(posedge clk_sys) disable iff (srst)
        (WIDE && st_q.act[0] && st_q.we[0]) |->
        (c_lwe[0] == {st_q.mask[1], st_q.mask[0]}))
        else $error("wide write mask not joined from both ports");

    a_mode_port: assert property (
        @(posedge clk_sys) disable iff (srst)
        (MODE != LDPR_TDP) |-> (!(|c_lwe[1]) && !(MODE != LDPR_SP
                                && c_rd[0])))
        else $error("port used against its role in this mode");

    a_bypass_lat: assert property (
        @(posedge clk_sys) disable iff (srst)
        (!OUT_REG_A && !WIDE && c_rd[0] && !clr_a) ##1 !clr_a |=>
        (rdata_a == $past(r_al[0][PIN_W-1:0])))
        else $error("bypassed read data late or wrong");

    a_outreg_lat: assert property (
        @(posedge clk_sys) disable iff (srst)
        (OUT_REG_A && !WIDE && c_rd[0] && !clr_a) ##1 !clr_a
        ##1 (!clr_a && en_a) |=> (rdata_a == $past(r_al[0][PIN_W-1:0], 2)))
        else $error("registered read data not one cycle later");

    a_ce_hold: assert property (
        @(posedge clk_sys) disable iff (srst)
        (OUT_REG_A && !en_a && !clr_a) |=> $stable(rdata_a))
        else $error("output register moved without enable");

    a_clear_out: assert property (
        @(posedge clk_sys) disable iff (srst)
        clr_a |=> (rdata_a == '0 && !st_q.act[0] && !(|c_lwe[0])))
        else $error("port A clear did not empty its registers");
endmodule

// *** shared/ldpr_pkg.sv ***
// Shared constants, mode type and width helpers for the large RAM
package ldpr_pkg;
    localparam int ARRAY_BITS = 589824;
    localparam int LANE_W     = 9;
    localparam int BYTE_W     = 8;
    localparam int LANES      = 16;
    localparam int WORD_W     = LANE_W * LANES;
    localparam int DEPTH      = 4096;
    localparam int WORD_AW    = 12;
    localparam int PORT_AW    = 16;
    localparam int PIN_W      = 72;
    localparam int MASK_W     = 8;
    localparam int LANE_IW    = 4;
    localparam int DEF_WIDTH  = 72;

    typedef enum {
        LDPR_TDP,
        LDPR_SDP,
        LDPR_SP,
        LDPR_FIFO
    } ldpr_mode_t;

    function automatic bit ldpr_width_ok(int w);
        return w inside {8, 9, 16, 18, 32, 36, 64, 72, 128, 144};
    endfunction

    function automatic bit ldpr_parity(int w);
        return (w % LANE_W) == 0;
    endfunction

    function automatic int ldpr_lanes(int w);
        return ldpr_parity(w) ? w / LANE_W : w / BYTE_W;
    endfunction
endpackage

// *** shared/ldpr_port_if.sv ***
// Array access channel between the port logic and the storage array
interface ldpr_port_if;
    import ldpr_pkg::*;
    logic                    rd;
    logic [LANES-1:0]        lane_we;
    logic [WORD_AW-1:0]      addr;
    logic [WORD_W-1:0]       wdata;
    logic [WORD_W-1:0]       rdata;
    modport ctrl (output rd, lane_we, addr, wdata, input rdata);
    modport mem  (input rd, lane_we, addr, wdata, output rdata);
endinterface
